// [pkg/gpfs_defs.svh]
// Constants of the pin function selector: offsets, field layout, codes, reset values.
`ifndef GPFS_DEFS_SVH
`define GPFS_DEFS_SVH

// Register byte offsets on the Avalon-MM slave.
`define GPFS_OFS_SEL_A 4'h0
`define GPFS_OFS_SEL_B 4'h4

// Field layout: ten 3-bit selectors per register, bits 31-30 reserved.
`define GPFS_SEL_W 3
`define GPFS_FIELDS 10
`define GPFS_USED_W 30
`define GPFS_USED_MASK 32'h3FFFFFFF
`define GPFS_SEL_RESET 30'h00000000

// Pins covered by the block and number of alternate functions.
`define GPFS_FIRST_PIN 10
`define GPFS_PINS 20
`define GPFS_ALTS 6

// Selector codes.
`define GPFS_CODE_INPUT 3'h0
`define GPFS_CODE_OUTPUT 3'h1
`define GPFS_CODE_ALT5 3'h2
`define GPFS_CODE_ALT4 3'h3
`define GPFS_CODE_ALT0 3'h4
`define GPFS_CODE_ALT1 3'h5
`define GPFS_CODE_ALT2 3'h6
`define GPFS_CODE_ALT3 3'h7

// Avalon-MM response codes.
`define GPFS_RESP_OKAY 2'h0
`define GPFS_RESP_DECODEERROR 2'h3

`endif

// [pkg/gpfs_pkg.sv]
// Types of the pin function selector: pin uses and the block state.
package gpfs_pkg;
`include "gpfs_defs.svh"

  typedef enum logic [2:0] {
    GPFS_USE_INPUT,
    GPFS_USE_OUTPUT,
    GPFS_USE_ALT0,
    GPFS_USE_ALT1,
    GPFS_USE_ALT2,
    GPFS_USE_ALT3,
    GPFS_USE_ALT4,
    GPFS_USE_ALT5
  } gpfs_use_e;

  typedef logic [`GPFS_PINS-1:0] gpfs_pins_t;

  typedef struct packed {
    logic [`GPFS_USED_W-1:0] sel_a;
    logic [`GPFS_USED_W-1:0] sel_b;
    logic waitrequest;
    logic [31:0] readdata;
    logic [1:0] response;
    gpfs_pins_t sync1;
    gpfs_pins_t sync2;
    gpfs_pins_t sync3;
    gpfs_pins_t pin_level;
    gpfs_pins_t pad_out;
    gpfs_pins_t pad_oe_n;
  } gpfs_state_s;

endpackage

// [core/gpfs_pin_function_select.sv]
// Function selector for general-purpose pins 10 to 29 with its Avalon-MM register slave.
//
// The Avalon-MM slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`include "gpfs_defs.svh"

module gpfs_pin_function_select #(
  parameter int PINS = `GPFS_PINS,
  parameter int ALTS = `GPFS_ALTS,
  // One bit per alternate function and pin; bit k*PINS+i set when a peripheral is wired.
  parameter logic [`GPFS_ALTS*`GPFS_PINS-1:0] ALT_PRESENT = '1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic [1:0] response,
  output logic waitrequest,
  // Plain output data from the set/clear logic, same clock
  input wire logic [`GPFS_PINS-1:0] gpio_out_level,
  // Alternate function sources, same clock
  input wire logic [`GPFS_ALTS-1:0][`GPFS_PINS-1:0] alt_out,
  input wire logic [`GPFS_ALTS-1:0][`GPFS_PINS-1:0] alt_drive,
  // Pads
  input wire logic [`GPFS_PINS-1:0] pad_in,
  output logic [`GPFS_PINS-1:0] pad_out,
  output logic [`GPFS_PINS-1:0] pad_oe_n,
  // Synchronised pad level for the level register and the peripherals
  output logic [`GPFS_PINS-1:0] pin_level
);

  localparam gpfs_pkg::gpfs_state_s RESET_STATE = '{
    sel_a: `GPFS_SEL_RESET,
    sel_b: `GPFS_SEL_RESET,
    waitrequest: 1'b1,
    readdata: 32'h00000000,
    response: `GPFS_RESP_OKAY,
    sync1: '0,
    sync2: '0,
    sync3: '0,
    pin_level: '0,
    pad_out: '0,
    pad_oe_n: '1
  };

  gpfs_pkg::gpfs_state_s state_q;
  gpfs_pkg::gpfs_state_s state_d;

  // Turns a selector code into the pin use it names.
  function automatic gpfs_pkg::gpfs_use_e decode_use(input logic [`GPFS_SEL_W-1:0] code);
    gpfs_pkg::gpfs_use_e use_v;
    use_v = gpfs_pkg::GPFS_USE_INPUT;
    unique case (code)
      `GPFS_CODE_INPUT: use_v = gpfs_pkg::GPFS_USE_INPUT;
      `GPFS_CODE_OUTPUT: use_v = gpfs_pkg::GPFS_USE_OUTPUT;
      `GPFS_CODE_ALT0: use_v = gpfs_pkg::GPFS_USE_ALT0;
      `GPFS_CODE_ALT1: use_v = gpfs_pkg::GPFS_USE_ALT1;
      `GPFS_CODE_ALT2: use_v = gpfs_pkg::GPFS_USE_ALT2;
      `GPFS_CODE_ALT3: use_v = gpfs_pkg::GPFS_USE_ALT3;
      `GPFS_CODE_ALT4: use_v = gpfs_pkg::GPFS_USE_ALT4;
      `GPFS_CODE_ALT5: use_v = gpfs_pkg::GPFS_USE_ALT5;
    endcase
    return use_v;
  endfunction

  // Merges a byte-enabled write into a selector register.
  function automatic logic [`GPFS_USED_W-1:0] merge_write(
    input logic [`GPFS_USED_W-1:0] old_v,
    input logic [31:0] data,
    input logic [3:0] be
  );
    logic [31:0] word;
    word = {2'b00, old_v};
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        word[8*b +: 8] = data[8*b +: 8];
      end
    end
    // The upper two bits never reach storage, so a write there is lost.
    word = word & `GPFS_USED_MASK;
    return word[`GPFS_USED_W-1:0];
  endfunction

  // Selector field of a pin, counted from the first covered pin.
  function automatic logic [`GPFS_SEL_W-1:0] pick_field(
    input logic [`GPFS_USED_W-1:0] sel_a,
    input logic [`GPFS_USED_W-1:0] sel_b,
    input int idx
  );
    logic [`GPFS_SEL_W-1:0] f;
    if (idx < `GPFS_FIELDS) begin
      f = sel_a[`GPFS_SEL_W*idx +: `GPFS_SEL_W];
    end else begin
      f = sel_b[`GPFS_SEL_W*(idx-`GPFS_FIELDS) +: `GPFS_SEL_W];
    end
    return f;
  endfunction

  // Index of the alternate function for a use, or ALTS for a plain use.
  function automatic int alt_index(input gpfs_pkg::gpfs_use_e use_v);
    int k;
    unique case (use_v)
      gpfs_pkg::GPFS_USE_ALT0: k = 0;
      gpfs_pkg::GPFS_USE_ALT1: k = 1;
      gpfs_pkg::GPFS_USE_ALT2: k = 2;
      gpfs_pkg::GPFS_USE_ALT3: k = 3;
      gpfs_pkg::GPFS_USE_ALT4: k = 4;
      gpfs_pkg::GPFS_USE_ALT5: k = 5;
      gpfs_pkg::GPFS_USE_INPUT, gpfs_pkg::GPFS_USE_OUTPUT: k = ALTS;
    endcase
    return k;
  endfunction

  always_comb begin
    logic req;
    logic hit_a;
    logic hit_b;
    logic [`GPFS_SEL_W-1:0] field;
    gpfs_pkg::gpfs_use_e use_v;
    int k;
    req = 1'b0;
    hit_a = 1'b0;
    hit_b = 1'b0;
    field = `GPFS_CODE_INPUT;
    use_v = gpfs_pkg::GPFS_USE_INPUT;
    k = 0;
    state_d = state_q;

    // Bus slave: one cycle of wait, then a single-cycle answer with waitrequest low.
    req = read | write;
    hit_a = address[3:2] == `GPFS_OFS_SEL_A >> 2;
    hit_b = address[3:2] == `GPFS_OFS_SEL_B >> 2;
    if (req && state_q.waitrequest) begin
      state_d.waitrequest = 1'b0;
      state_d.readdata = 32'h00000000;
      state_d.response = (hit_a || hit_b) ? `GPFS_RESP_OKAY : `GPFS_RESP_DECODEERROR;
      if (!write) begin
        if (hit_a) begin
          state_d.readdata = {2'b00, state_q.sel_a};
        end
        if (hit_b) begin
          state_d.readdata = {2'b00, state_q.sel_b};
        end
      end
    end else begin
      // The write lands on the answering edge, the one where the master sees waitrequest low.
      if (write && !state_q.waitrequest && hit_a) begin
        state_d.sel_a = merge_write(state_q.sel_a, writedata, byteenable);
      end
      if (write && !state_q.waitrequest && hit_b) begin
        state_d.sel_b = merge_write(state_q.sel_b, writedata, byteenable);
      end
      // The master releases on the answering edge; rearm for the next request.
      state_d.waitrequest = 1'b1;
    end

    // Pad input: three stages, a change counts once the second and third agree.
    state_d.sync1 = pad_in;
    state_d.sync2 = state_q.sync1;
    state_d.sync3 = state_q.sync2;
    for (int i = 0; i < PINS; i++) begin
      if (state_q.sync2[i] == state_q.sync3[i]) begin
        state_d.pin_level[i] = state_q.sync3[i];
      end
    end

    // Pad drive is computed from the next selectors so that a write shows
    // on the pad from the cycle right after the answering edge.
    for (int i = 0; i < PINS; i++) begin
      field = pick_field(state_d.sel_a, state_d.sel_b, i);
      use_v = decode_use(field);
      k = alt_index(use_v);
      if (use_v == gpfs_pkg::GPFS_USE_INPUT) begin
        state_d.pad_out[i] = 1'b0;
        state_d.pad_oe_n[i] = 1'b1;
      end else if (use_v == gpfs_pkg::GPFS_USE_OUTPUT) begin
        state_d.pad_out[i] = gpio_out_level[i];
        state_d.pad_oe_n[i] = 1'b0;
      end else if (ALT_PRESENT[k*PINS + i]) begin
        state_d.pad_out[i] = alt_out[k][i];
        state_d.pad_oe_n[i] = ~alt_drive[k][i];
      end else begin
        // A missing peripheral's line is tied low and driven as such.
        state_d.pad_out[i] = 1'b0;
        state_d.pad_oe_n[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= RESET_STATE;
    end else begin
      state_q <= state_d;
    end
  end

  assign readdata = state_q.readdata;
  assign response = state_q.response;
  assign waitrequest = state_q.waitrequest;
  assign pad_out = state_q.pad_out;
  assign pad_oe_n = state_q.pad_oe_n;
  assign pin_level = state_q.pin_level;

endmodule

// [verification/gpfs_pin_function_select_sva.sv]
// Bus and reset assertions of the pin function selector.
`timescale 1ns/1ns
module gpfs_pin_function_select_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register bus
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] readdata,
  input wire logic [1:0] response,
  input wire logic waitrequest,
  // Pads
  input wire logic [19:0] pad_oe_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire logic req = read | write;
  property p_ans; req && waitrequest |=> !waitrequest; endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  property p_one; !waitrequest |=> waitrequest; endproperty
  a_one: assert property (p_one) else $error("long answer");
  property p_idle; !req && waitrequest |=> waitrequest; endproperty
  a_idle: assert property (p_idle) else $error("stray answer");
  property p_rsv; !waitrequest && read |-> readdata[31:30] == 2'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved set");
  property p_unm; !waitrequest && address[3] |-> response == 2'h3; endproperty
  a_unm: assert property (p_unm) else $error("bad response");
  property p_map; !waitrequest && !address[3] |-> response == 2'h0; endproperty
  a_map: assert property (p_map) else $error("bad okay");
  property p_unrd; !waitrequest && read && address[3] |-> readdata == 32'h0; endproperty
  a_unrd: assert property (p_unrd) else $error("unmapped data");
  property p_rst; $rose(rst_n) |-> waitrequest && pad_oe_n == 20'hFFFFF; endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  c_wr: cover property (write && !waitrequest);
  c_rd: cover property (read && !waitrequest);
  c_unm: cover property (address[3] && !waitrequest);
endmodule
bind gpfs_pin_function_select gpfs_pin_function_select_sva u_sva (.clk(clk), .rst_n(rst_n),
  .address(address), .read(read), .write(write), .readdata(readdata), .response(response),
  .waitrequest(waitrequest), .pad_oe_n(pad_oe_n));

// [verification/test_gpfs_pin_function_select.sv]
// Testbench of the pin function selector: registers and pad routing.
`timescale 1ns/1ns
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fails++; $display("BAD %0t %h %h", $time, a, b); end end
module test_gpfs_pin_function_select;
  // Alternate 0 of pin 10 is left unwired so the tied-low path is reached.
  localparam logic [119:0] AP = ~120'h1;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [3:0] byteenable = 4'hF;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic [1:0] response;
  logic waitrequest;
  logic [19:0] gpio_out_level = 20'hA5C3A;
  logic [5:0][19:0] alt_out;
  logic [5:0][19:0] alt_drive;
  logic [19:0] pad_in = 20'h0;
  logic [19:0] pad_out;
  logic [19:0] pad_oe_n;
  logic [19:0] pin_level;
  logic [31:0] rd;
  logic [1:0] rs;
  int fails = 0;
  int n_checks = 0;
  always #4 clk = ~clk;
  gpfs_pin_function_select #(.ALT_PRESENT(AP)) u_gpfs_pin_function_select (.clk(clk), .rst_n(rst_n),
    .address(address), .read(read), .write(write), .byteenable(byteenable), .writedata(writedata),
    .readdata(readdata), .response(response), .waitrequest(waitrequest), .gpio_out_level(gpio_out_level),
    .alt_out(alt_out), .alt_drive(alt_drive), .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
    .pin_level(pin_level));
  task test_done;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // The request stands until the rising edge that sees waitrequest low; data is taken there.
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
    int n;
    @(posedge clk);
    read <= ~w;
    write <= w;
    address <= a;
    writedata <= d;
    byteenable <= be;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    if (waitrequest !== 1'b0) begin
      fails++;
      test_done;
    end
    rd = readdata;
    rs = response;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  // The synchronised level follows a steady pad after the three stages.
  task t_level;
    pad_in <= 20'h5A5A5;
    repeat (5) @(posedge clk);
    @(negedge clk);
    `CHK(pin_level, 20'h5A5A5)
  endtask
  function automatic logic [1:0] exp_pin(input logic [2:0] c, input int i);
    int k;
    if (c == 3'h0) return 2'b01;
    if (c == 3'h1) return {gpio_out_level[i], 1'b0};
    k = c[2] ? c - 4 : 7 - c;
    if (!AP[k * 20 + i]) return 2'b00;
    return {alt_out[k][i], ~alt_drive[k][i]};
  endfunction
  task t_reset;
    bus(1'b0, 4'h0, 32'h0, 4'hF);
    `CHK(rd, 32'h0)
    bus(1'b0, 4'h4, 32'h0, 4'hF);
    `CHK(rd, 32'h0)
    `CHK(pad_oe_n, 20'hFFFFF)
  endtask
  task t_rsv;
    bus(1'b1, 4'h0, 32'hFFFFFFFF, 4'hF);
    bus(1'b0, 4'h0, 32'h0, 4'hF);
    `CHK(rd, 32'h3FFFFFFF)
    bus(1'b1, 4'h0, 32'h0, 4'h1);
    bus(1'b0, 4'h0, 32'h0, 4'hF);
    `CHK(rd, 32'h3FFFFF00)
  endtask
  task t_unmap;
    bus(1'b1, 4'h8, 32'h0, 4'hF);
    `CHK(rs, 2'h3)
    bus(1'b0, 4'hC, 32'h0, 4'hF);
    `CHK(rd, 32'h0)
    bus(1'b0, 4'h0, 32'h0, 4'hF);
    `CHK(rd, 32'h3FFFFF00)
    `CHK(rs, 2'h0)
  endtask
  // Every code lands on every pin across the loop, each field differing from its neighbours.
  task t_codes;
    logic [29:0] va;
    logic [29:0] vb;
    logic [2:0] c;
    for (int s = 0; s < 8; s++) begin
      for (int i = 0; i < 10; i++) begin
        va[3 * i +: 3] = 3'(i + s);
        vb[3 * i +: 3] = 3'(i + s + 3);
      end
      bus(1'b1, 4'h0, {2'h3, va}, 4'hF);
      bus(1'b1, 4'h4, {2'h3, vb}, 4'hF);
      @(negedge clk);
      for (int i = 0; i < 20; i++) begin
        c = i < 10 ? va[3 * i +: 3] : vb[3 * (i - 10) +: 3];
        `CHK({pad_out[i], pad_oe_n[i]}, exp_pin(c, i))
      end
      bus(1'b0, 4'h0, 32'h0, 4'hF);
      `CHK(rd, {2'h0, va})
      bus(1'b0, 4'h4, 32'h0, 4'hF);
      `CHK(rd, {2'h0, vb})
    end
  endtask
  initial begin
    for (int k = 0; k < 6; k++) begin
      alt_out[k] = 20'h3C96F ^ 20'(k * 'h1111);
      alt_drive[k] = 20'h5A0F3 ^ 20'(k * 'h0F0F);
    end
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_rsv;
    t_unmap;
    t_codes;
    t_level;
    test_done;
  end
endmodule
